// ===== design/dcr_pkg.sv
// Shared constants for the decade counter readout control block
package dcr_pkg;

	// ==========================================================
	// Clock and scan timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SCAN_PERIOD_US = 1000;
	localparam int SCAN_DIV_CYCLES = (SCAN_PERIOD_US * 1000000) / CLK_PERIOD_PS;

	// ==========================================================
	// Counter geometry
	localparam int DECADES = 6;
	localparam int DIGIT_W = 4;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [3:0] BLANK_CODE = 4'hF;

	// ==========================================================
	// Segment patterns, bit 0 = a ... bit 6 = g
	localparam logic [6:0] SEG_ALL = 7'h7F;
	localparam logic [6:0] SEG_OFF = 7'h00;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;

	// CTRL fields
	localparam int CTRL_ROLE_LSB = 0;
	localparam int CTRL_LAMP_BIT = 2;
	localparam int CTRL_RUN_BIT = 3;
	localparam int CTRL_FRST_BIT = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Role encodings
	localparam logic [1:0] ROLE_NORMAL = 2'h0;
	localparam logic [1:0] ROLE_MASTER = 2'h1;
	localparam logic [1:0] ROLE_SLAVE = 2'h2;

	// ==========================================================
	// Print sequence states
	typedef enum logic [3:0] {
		ST_SCAN = 4'h1,
		ST_WAIT = 4'h2,
		ST_SEND = 4'h4,
		ST_DONE = 4'h8
	} dcr_state_t;

endpackage : dcr_pkg

// ===== design/dcr_dec_if.sv
// Link between the controller and one BCD decade
`timescale 1ns/1ps
interface dcr_dec_if;
	logic inc;
	logic clr;
	logic carry;
	logic [3:0] q;
	modport dec (input inc, input clr, output carry, output q);
	modport ctl (output inc, output clr, input carry, input q);
endinterface : dcr_dec_if

// ===== design/dcr_decade.sv
// One 1-2-4-8 BCD decade of the counting register
`timescale 1ns/1ps
module dcr_decade
	import dcr_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// Decade link
	dcr_dec_if.dec dec
);

	// ==========================================================
	// Counting
	logic [3:0] q_ff;
	wire at_max = (q_ff == DIGIT_MAX);
	wire [3:0] nxt_q = at_max ? 4'h0 : 4'(q_ff + 4'h1);

	always_ff @(posedge i_clock)
	begin
		if (i_reset || dec.clr)
			q_ff <= 4'h0;
		else if (dec.inc)
			q_ff <= nxt_q; // RULE25
	end

	// Carry only from a real count, never from a clear
	assign dec.carry = dec.inc && at_max && !dec.clr; // RULE25
	assign dec.q = q_ff;

	AST_DEC_WRAP: assert property (@(posedge i_clock) disable iff (i_reset) // RULE25
		dec.inc && !dec.clr && at_max |=> q_ff == 4'h0)
		else $error("decade did not wrap from nine to zero");

endmodule : dcr_decade

// ===== design/dcr_top.sv
// Six-decade counter with display scan, print readout and role routing
//
// Behaviour
// RULE1: decode common code, select digit position
// RULE2: segments a..g in standard layout
// RULE3: lamp test lights every segment
// RULE4: arm zero blanking at most-significant digit
// RULE5: nonzero code or lamp test clears blanking
// RULE6: least-significant digit always displayed; code blanks it in ST_DONE
// RULE7: preset closes the count gate
// RULE8: print stops scan, holds first digit, blanks
// RULE9: wait for previous module done input
// RULE10: on previous done, drive data lines
// RULE11: most-significant digit is sent first
// RULE12: each print advance steps to next digit
// RULE13: after last digit, done isolates and blanks
// RULE14: control module picks next program step
// RULE15: master drives gate and reset out
// RULE16: slave accepts system gate and reset
// RULE17: normal ignores and drives no system lines
// RULE18: any low reset source gives local reset
// RULE19: local reset clears all six decades
// RULE20: reset-caused carry gives no overflow pulse
// RULE21: local reset clears overflow indicator
// RULE22: local reset closes gate, indicator off
// RULE23: six selects in turn, then wrap
// RULE24: scan driven by about 1 kHz tick
// RULE25: BCD decades chained by carry
// RULE26: first overflow sets sticky indicator
// RULE27: data drivers off unless this module sends
`timescale 1ns/1ps
module dcr_top
	import dcr_pkg::*;
#(
	parameter int SCAN_DIV = SCAN_DIV_CYCLES
)
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Front and rear pins
	input wire logic i_count_pulse,
	input wire logic i_gate_input,
	input wire logic i_rear_reset_n,
	input wire logic i_powerup_reset_n,
	// Printer loop
	input wire logic i_preset,
	input wire logic i_print,
	input wire logic i_prev_module_done,
	input wire logic i_print_advance,
	output logic [3:0] o_sys_data,
	output logic o_sys_data_oe,
	output logic o_this_module_done,
	// System gate and reset lines, open drain; gate high when open, reset active low
	input wire logic i_sys_gate,
	input wire logic i_sys_reset_n,
	output logic o_sys_gate_out,
	output logic o_sys_gate_oe,
	output logic o_sys_reset_out,
	output logic o_sys_reset_oe,
	// Six-digit display and indicators
	output logic [6:0] o_seg,
	output logic [5:0] o_digit_sel,
	output logic o_overflow_pulse,
	output logic o_overflow_indicator,
	output logic o_gate_indicator
);

	// ==========================================================
	// Elaboration check
	if (SCAN_DIV < 2) begin : g_bad_div
		$error("SCAN_DIV must be at least 2");
	end

	// ==========================================================
	// Input synchronisers, first stage read only by the second
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] meta_ff;
	logic [NSYNC-1:0] sync_ff;
	wire [NSYNC-1:0] raw_in = {i_count_pulse, i_gate_input, i_rear_reset_n,
		i_powerup_reset_n, i_preset, i_print, i_prev_module_done, i_print_advance,
		i_sys_gate, i_sys_reset_n};

	always_ff @(posedge i_clock)
	begin
		meta_ff <= raw_in;
		sync_ff <= meta_ff;
	end

	wire cnt_s = sync_ff[9];
	wire gate_in_s = sync_ff[8];
	wire rear_n_s = sync_ff[7];
	wire pwr_n_s = sync_ff[6];
	wire preset_s = sync_ff[5];
	wire print_s = sync_ff[4];
	wire prev_done_s = sync_ff[3];
	wire adv_s = sync_ff[2];
	wire sys_gate_s = sync_ff[1];
	wire sys_rst_n_s = sync_ff[0];

	logic cnt_d_ff;
	logic adv_d_ff;
	always_ff @(posedge i_clock)
	begin
		cnt_d_ff <= cnt_s;
		adv_d_ff <= adv_s;
	end
	wire cnt_edge = cnt_s && !cnt_d_ff;
	wire adv_edge = adv_s && !adv_d_ff;

	// ==========================================================
	// APB registers, one wait state per access
	logic [1:0] role_ff;
	logic lamp_ff;
	logic run_ff;
	logic frst_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [31:0] rd_mux;

	wire acc = i_psel && i_penable;
	wire done_acc = acc && pready_ff;
	wire hit_ctrl = (i_paddr == OFS_CTRL);
	wire hit_stat = (i_paddr == OFS_STATUS);
	wire hit_cnt = (i_paddr == OFS_COUNT);
	wire mapped = hit_ctrl || hit_stat || hit_cnt;
	wire wr_ctrl = done_acc && i_pwrite && hit_ctrl;

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			{frst_ff, run_ff, lamp_ff, role_ff} <= {1'b0, CTRL_RESET};
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end
		else
		begin
			pready_ff <= acc && !pready_ff;
			pslverr_ff <= acc && !pready_ff && !mapped;
			prdata_ff <= (acc && !pready_ff && !i_pwrite) ? rd_mux : 32'h0;
			// Front reset bit is a one-cycle press, it never sticks
			frst_ff <= wr_ctrl && i_pwdata[CTRL_FRST_BIT];
			if (wr_ctrl)
			begin
				role_ff <= i_pwdata[CTRL_ROLE_LSB +: 2];
				lamp_ff <= i_pwdata[CTRL_LAMP_BIT];
				run_ff <= i_pwdata[CTRL_RUN_BIT];
			end
		end
	end

	// ==========================================================
	// Role routing
	wire is_master = (role_ff == ROLE_MASTER);
	wire is_slave = (role_ff == ROLE_SLAVE);
	wire sys_rst_take = is_slave && !sys_rst_n_s; // RULE16 RULE17

	// ==========================================================
	// Local reset
	logic lrst_ff;
	wire nxt_lrst = !pwr_n_s || !rear_n_s || frst_ff || sys_rst_take; // RULE18

	// ==========================================================
	// Gate
	wire own_gate = run_ff && gate_in_s;
	wire gate_src = is_slave ? sys_gate_s : own_gate; // RULE15 RULE16 RULE17
	wire gate_open = gate_src && !preset_s && !lrst_ff; // RULE7 RULE22
	wire cnt_en = cnt_edge && gate_open;

	// ==========================================================
	// Counting register
	dcr_dec_if dlink [DECADES] ();
	logic [4*DECADES-1:0] cnt_bus;

	for (genvar k = 0; k < DECADES; k++) begin : g_dec
		assign dlink[k].clr = lrst_ff; // RULE19
		if (k == 0) begin : g_lsd
			assign dlink[k].inc = cnt_en && !lrst_ff;
		end
		else begin : g_up
			assign dlink[k].inc = dlink[k-1].carry; // RULE25
		end
		assign cnt_bus[4*k +: 4] = dlink[k].q;
		dcr_decade u_dec (
			.i_clock(i_clock),
			.i_reset(i_reset),
			.dec(dlink[k])
		);
	end

	wire top_carry = dlink[DECADES-1].carry;

	// ==========================================================
	// Scan tick divider
	localparam int DIV_W = $clog2(SCAN_DIV);
	logic [DIV_W-1:0] div_ff;
	wire div_wrap = (div_ff == DIV_W'(SCAN_DIV - 1));
	logic tick_ff;

	// ==========================================================
	// Scanner and print sequence
	dcr_state_t state_ff;
	dcr_state_t nxt_state;
	logic [5:0] sel_ff;
	logic [5:0] nxt_sel;
	logic lzb_ff;

	wire sel_msd = sel_ff[0];
	wire sel_lsd = sel_ff[5];

	always_comb
	begin
		nxt_state = state_ff;
		nxt_sel = sel_ff;
		unique case (state_ff)
			ST_SCAN:
			begin
				if (print_s)
				begin
					nxt_state = ST_WAIT;
					nxt_sel = 6'h01; // RULE8
				end
				else if (tick_ff)
					nxt_sel = {sel_ff[4:0], sel_ff[5]}; // RULE23 RULE24
			end
			ST_WAIT:
			begin
				nxt_sel = 6'h01; // RULE8 RULE11
				if (!print_s)
					nxt_state = ST_SCAN;
				else if (prev_done_s)
					nxt_state = ST_SEND; // RULE9 RULE10
			end
			ST_SEND:
			begin
				if (!print_s)
					nxt_state = ST_SCAN;
				else if (adv_edge)
				begin
					if (sel_lsd)
						nxt_state = ST_DONE; // RULE13
					else
						nxt_sel = {sel_ff[4:0], 1'b0}; // RULE12
				end
			end
			ST_DONE:
			begin
				if (!print_s)
				begin
					nxt_state = ST_SCAN;
					nxt_sel = 6'h01;
				end
			end
		endcase
	end

	// ==========================================================
	// Digit mux and display decode
	logic [3:0] digit;
	always_comb
	begin
		digit = 4'h0;
		for (int k = 0; k < DECADES; k++)
			if (sel_ff[k])
				digit = cnt_bus[4*(DECADES-1-k) +: 4]; // RULE1
	end

	wire clamp = (state_ff == ST_WAIT) || (state_ff == ST_DONE);
	wire [3:0] code = clamp ? BLANK_CODE : digit; // RULE8 RULE13
	wire lz_hit = (sel_msd || lzb_ff) && !sel_lsd; // RULE4 RULE6
	wire lz_blank = lz_hit && (code == 4'h0) && !lamp_ff; // RULE5

	function automatic logic [6:0] seg_of(input logic [3:0] c);
		unique case (c)
			4'h0: seg_of = 7'h3F;
			4'h1: seg_of = 7'h06;
			4'h2: seg_of = 7'h5B;
			4'h3: seg_of = 7'h4F;
			4'h4: seg_of = 7'h66;
			4'h5: seg_of = 7'h6D;
			4'h6: seg_of = 7'h7D;
			4'h7: seg_of = 7'h07;
			4'h8: seg_of = 7'h7F;
			4'h9: seg_of = 7'h6F;
			default: seg_of = SEG_OFF;
		endcase
	endfunction : seg_of

	wire [6:0] nxt_seg = lamp_ff ? SEG_ALL : (lz_blank ? SEG_OFF : seg_of(code)); // RULE2 RULE3
	wire step = (nxt_sel != sel_ff);

	// ==========================================================
	// Sequential state
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			div_ff <= '0;
			tick_ff <= 1'b0;
			state_ff <= ST_SCAN;
			sel_ff <= 6'h01;
			lzb_ff <= 1'b1;
			lrst_ff <= 1'b0;
		end
		else
		begin
			// Oscillator is held while printing so the scan stays put
			div_ff <= (div_wrap || print_s) ? '0 : DIV_W'(div_ff + 1'b1);
			tick_ff <= div_wrap && !print_s; // RULE8 RULE24
			state_ff <= nxt_state;
			sel_ff <= nxt_sel;
			if (step)
				lzb_ff <= lz_blank || nxt_sel[0]; // RULE4 RULE5
			lrst_ff <= nxt_lrst;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			o_seg <= SEG_OFF;
			o_digit_sel <= 6'h00;
			o_sys_data <= 4'h0;
			o_sys_data_oe <= 1'b0;
			o_this_module_done <= 1'b0;
			o_sys_gate_oe <= 1'b0;
			o_sys_reset_oe <= 1'b0;
			o_overflow_pulse <= 1'b0;
			o_overflow_indicator <= 1'b0;
			o_gate_indicator <= 1'b0;
		end
		else
		begin
			o_seg <= nxt_seg;
			o_digit_sel <= sel_ff; // RULE1
			o_sys_data <= (nxt_state == ST_SEND) ? digit : 4'h0;
			o_sys_data_oe <= (nxt_state == ST_SEND); // RULE10 RULE27
			o_this_module_done <= (nxt_state == ST_DONE); // RULE13
			o_sys_gate_oe <= is_master && !(own_gate && !lrst_ff); // RULE15
			o_sys_reset_oe <= is_master && lrst_ff; // RULE15
			o_overflow_pulse <= top_carry; // RULE20
			if (lrst_ff)
				o_overflow_indicator <= 1'b0; // RULE21
			else if (top_carry)
				o_overflow_indicator <= 1'b1; // RULE26
			o_gate_indicator <= gate_open; // RULE22
		end
	end

	// Open-drain lines only ever pull low
	assign o_sys_gate_out = 1'b0;
	assign o_sys_reset_out = 1'b0;
	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;

	always_comb
	begin
		rd_mux = 32'h0;
		if (hit_ctrl)
			rd_mux[4:0] = {1'b0, run_ff, lamp_ff, role_ff};
		else if (hit_stat)
			rd_mux[9:0] = {sel_ff, (state_ff != ST_SCAN), o_this_module_done,
				o_gate_indicator, o_overflow_indicator};
		else if (hit_cnt)
			rd_mux[23:0] = cnt_bus;
	end

	// ==========================================================
	// Checks
	AST_LAMP: assert property (@(posedge i_clock) disable iff (i_reset) // RULE3
		lamp_ff && $stable(lamp_ff) |=> o_seg == SEG_ALL)
		else $error("lamp test did not light all segments");

	AST_PRINT_BLANK: assert property (@(posedge i_clock) disable iff (i_reset) // RULE8
		state_ff == ST_WAIT && !lamp_ff |-> sel_msd ##1 o_seg == SEG_OFF)
		else $error("waiting module not held at first digit and blank");

	AST_PRESET_HOLD: assert property (@(posedge i_clock) disable iff (i_reset) // RULE7
		preset_s && !lrst_ff |=> $stable(cnt_bus))
		else $error("count changed during preset");

	AST_DONE_SET: assert property (@(posedge i_clock) disable iff (i_reset) // RULE13
		state_ff == ST_SEND && print_s && adv_edge && sel_lsd
		|=> o_this_module_done && !o_sys_data_oe)
		else $error("done not set after last digit");

	AST_OE_OWN: assert property (@(posedge i_clock) disable iff (i_reset) // RULE27
		o_sys_data_oe |-> state_ff == ST_SEND)
		else $error("data lines driven while not sending");

	AST_NO_DRIVE: assert property (@(posedge i_clock) disable iff (i_reset) // RULE16
		!is_master ##1 !is_master |-> !o_sys_gate_oe && !o_sys_reset_oe)
		else $error("system line driven outside master role");

	AST_RST_CLEAR: assert property (@(posedge i_clock) disable iff (i_reset) // RULE19
		lrst_ff |=> cnt_bus == '0 && !o_overflow_indicator)
		else $error("local reset did not clear count and overflow");

	AST_SCAN_WRAP: assert property (@(posedge i_clock) disable iff (i_reset) // RULE23
		state_ff == ST_SCAN && !print_s && tick_ff && sel_lsd |=> sel_msd)
		else $error("scan did not wrap to first digit");

	AST_OVF_CAUSE: assert property (@(posedge i_clock) disable iff (i_reset) // RULE20
		o_overflow_pulse |-> $past(cnt_en) && !$past(lrst_ff))
		else $error("overflow pulse without a count");

	AST_LSD_SHOWN: assert property (@(posedge i_clock) disable iff (i_reset) // RULE6
		state_ff == ST_SCAN && sel_lsd |=> o_seg != SEG_OFF)
		else $error("least significant digit blanked");

endmodule : dcr_top

// ===== dv/dcr_printer_model.sv
// Printer control model that reads one counter module out over the print loop
`timescale 1ns/1ps
module dcr_printer_model
(
	// Clock and bench control
	input wire logic i_clock,
	input wire logic i_start,
	input wire logic i_slow,
	// Lines from the counter module
	input wire logic [3:0] i_sys_data,
	input wire logic i_sys_data_oe,
	input wire logic i_done,
	// Lines to the counter module and bench
	output logic o_print,
	output logic o_prev_done,
	output logic o_advance,
	output logic [23:0] o_digits,
	output logic o_finished
);
	// ==========================================================
	// Readout sequence, slow mode stretches the printer's accept time
	initial
	begin
		int n;
		o_print <= 1'h0;
		o_prev_done <= 1'h0;
		o_advance <= 1'h0;
		o_digits <= 24'h0;
		o_finished <= 1'h0;
		forever
		begin
			@(posedge i_clock);
			if (i_start !== 1'h1)
				o_finished <= 1'h0;
			else if (o_finished !== 1'h1)
			begin
				o_print <= 1'h1;
				repeat (10) @(posedge i_clock);
				o_prev_done <= 1'h1;
				for (int k = 0; k < 6; k++)
				begin
					n = 0;
					while (i_sys_data_oe !== 1'h1 && n < 40)
					begin
						@(posedge i_clock);
						n++;
					end
					repeat (i_slow ? 9 : 3) @(posedge i_clock);
					o_digits <= {o_digits[19:0], i_sys_data};
					o_advance <= 1'h1;
					repeat (4) @(posedge i_clock);
					o_advance <= 1'h0;
					repeat (4) @(posedge i_clock);
				end
				n = 0;
				while (i_done !== 1'h1 && n < 20)
				begin
					@(posedge i_clock);
					n++;
				end
				// Hold print a while so the done state can be observed
				repeat (8) @(posedge i_clock);
				o_print <= 1'h0;
				o_prev_done <= 1'h0;
				o_finished <= (n < 20);
			end
		end
	end
endmodule : dcr_printer_model

// ===== dv/dcr_top_bench.sv
// Self-checking bench for the decade counter readout control block
`timescale 1ns/1ps
module dcr_top_bench;
	import dcr_pkg::*;
	// ==========================================================
	// Signals
	logic i_clock = 1'h0, i_reset = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, seed = 32'h8F89FE6D;
	logic i_count_pulse = 1'h0, i_gate_input = 1'h1, i_rear_reset_n = 1'h1;
	logic i_powerup_reset_n = 1'h1, i_preset = 1'h0, i_print, i_prev_module_done;
	logic i_print_advance, i_sys_gate, i_sys_reset_n, o_pready, o_pslverr, fin;
	logic o_sys_data_oe, o_this_module_done, o_sys_gate_out, o_sys_gate_oe;
	logic o_sys_reset_out, o_sys_reset_oe, o_overflow_pulse, o_overflow_indicator;
	logic o_gate_indicator, ext_gate_low = 1'h0, ext_reset_low = 1'h0, start = 1'h0;
	logic slow = 1'h0;
	logic [3:0] o_sys_data;
	logic [6:0] o_seg;
	logic [5:0] o_digit_sel;
	logic [23:0] digits;
	logic [33:0] note_q[$];
	logic [33:0] note;
	int miscompares = 0, comparisons = 0, total = 0, oflow = 0, n;
	// Open-drain system lines with pull-up, another module may pull them low
	assign i_sys_gate = !(o_sys_gate_oe === 1'h1 || ext_gate_low);
	assign i_sys_reset_n = !(o_sys_reset_oe === 1'h1 || ext_reset_low);
	always #2.5 i_clock = !i_clock;
	dcr_top #(.SCAN_DIV(8)) dcr_top_i (.*);
	dcr_printer_model dcr_printer_model_i (.i_clock(i_clock), .i_start(start),
		.i_slow(slow), .i_sys_data(o_sys_data), .i_sys_data_oe(o_sys_data_oe),
		.i_done(o_this_module_done), .o_print(i_print), .o_prev_done(i_prev_module_done),
		.o_advance(i_print_advance), .o_digits(digits), .o_finished(fin));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] bcd(input int v);
		logic [31:0] r;
		r = 32'h0;
		for (int k = 0; k < 6; k++)
		begin
			r[4*k +: 4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction : bcd
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'h1)
		begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// Reads note the expected word; the answer monitor compares it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		int k;
		@(posedge i_clock);
		note_q.push_back({w, e, d});
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		i_penable <= 1'h0;
		@(posedge i_clock);
		i_penable <= 1'h1;
		k = 0;
		do
		begin
			@(posedge i_clock);
			k++;
		end
		while (o_pready !== 1'h1 && k < 20);
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		if (k >= 20)
			chk(1'h0, "no apb answer");
	endtask : apb
	always @(posedge i_clock)
	begin
		if (o_overflow_pulse === 1'h1)
			oflow++;
		if (o_pready === 1'h1 && note_q.size() > 0)
		begin
			note = note_q.pop_front();
			chk(o_pslverr === note[32] && (note[33] || o_prdata === note[31:0]), "apb answer");
		end
	end
	task automatic pulses(input int c);
		repeat (c)
		begin
			@(posedge i_clock);
			i_count_pulse <= 1'h1;
			repeat (4) @(posedge i_clock);
			i_count_pulse <= 1'h0;
			repeat (3) @(posedge i_clock);
		end
		repeat (8) @(posedge i_clock);
	endtask : pulses
	task automatic show(input logic [5:0] s, input logic [6:0] e, input int b);
		int k;
		k = 0;
		// Entering late in the slot would look at the next digit, so catch its start
		while (o_digit_sel === s && k < b)
		begin
			@(negedge i_clock);
			k++;
		end
		while (o_digit_sel !== s && k < b)
		begin
			@(negedge i_clock);
			k++;
		end
		repeat (2) @(negedge i_clock);
		chk(k < b && o_seg === e, "display");
	endtask : show
	task automatic hi(ref logic x, input int b);
		int k;
		k = 0;
		while (x !== 1'h1 && k < b)
		begin
			@(negedge i_clock);
			k++;
		end
		chk(x === 1'h1, "wait");
	endtask : hi
	// ==========================================================
	// Scenarios
	initial
	begin
		repeat (5) @(posedge i_clock);
		i_reset <= 1'h0;
		repeat (4) @(posedge i_clock);
		apb(0, OFS_CTRL, 32'h0, 0);
		apb(1, 8'h0C, 32'hF, 1);
		apb(0, 8'h0C, 32'h0, 1);
		apb(1, OFS_CTRL, 32'h8, 0);
		pulses(102);
		total = 102;
		apb(0, OFS_COUNT, bcd(total), 0);
		show(6'h01, SEG_OFF, 60);
		show(6'h02, SEG_OFF, 12);
		show(6'h04, SEG_OFF, 12);
		show(6'h08, 7'h06, 12);
		show(6'h10, 7'h3F, 12);
		show(6'h20, 7'h5B, 12);
		show(6'h01, SEG_OFF, 12);
		apb(1, OFS_CTRL, 32'hC, 0);
		for (int k = 0; k < 6; k++)
			show(6'h01 << k, SEG_ALL, 60);
		apb(1, OFS_CTRL, 32'h8, 0);
		i_preset <= 1'h1;
		pulses(3);
		apb(0, OFS_COUNT, bcd(total), 0);
		i_preset <= 1'h0;
		for (int s = 0; s < 2; s++)
		begin
			@(posedge i_clock);
			slow <= s[0];
			start <= 1'h1;
			repeat (9) @(negedge i_clock);
			chk(o_seg === SEG_OFF && o_sys_data_oe === 1'h0 && o_digit_sel === 6'h01, "wait");
			hi(o_this_module_done, 400);
			@(negedge i_clock);
			chk(o_sys_data_oe === 1'h0 && o_seg === SEG_OFF, "done");
			hi(fin, 40);
			chk({8'h00, digits} === bcd(total), "printed digits");
			@(posedge i_clock);
			start <= 1'h0;
		end
		// Three local reset sources in turn: rear pin, power-up, front switch
		for (int r = 0; r < 3; r++)
		begin
			n = int'(rnd() % 32'h5) + 1;
			pulses(n);
			total += n;
			apb(0, OFS_COUNT, bcd(total), 0);
			i_rear_reset_n <= (r != 0);
			i_powerup_reset_n <= (r != 1);
			if (r == 2)
				apb(1, OFS_CTRL, 32'h18, 0);
			repeat (8) @(negedge i_clock);
			if (r == 0)
				chk(o_gate_indicator === 1'h0, "gate in reset");
			@(posedge i_clock);
			i_rear_reset_n <= 1'h1;
			i_powerup_reset_n <= 1'h1;
			total = 0;
			apb(0, OFS_COUNT, 32'h0, 0);
		end
		chk(o_overflow_indicator === 1'h0 && oflow == 0, "overflow");
		show(6'h10, SEG_OFF, 60);
		show(6'h20, 7'h3F, 12);
		apb(1, OFS_CTRL, 32'h9, 0);
		ext_gate_low <= 1'h1;
		n = int'(rnd() % 32'h5) + 1;
		pulses(n);
		total = n;
		apb(0, OFS_COUNT, bcd(total), 0);
		apb(1, OFS_CTRL, 32'h1, 0);
		repeat (4) @(negedge i_clock);
		chk(o_sys_gate_oe === 1'h1, "master gate");
		apb(1, OFS_CTRL, 32'h19, 0);
		hi(o_sys_reset_oe, 12);
		apb(1, OFS_CTRL, 32'hA, 0);
		pulses(3);
		ext_gate_low <= 1'h0;
		@(negedge i_clock);
		chk(o_sys_gate_oe === 1'h0 && o_sys_reset_oe === 1'h0, "slave drive");
		chk(o_sys_gate_out === 1'h0 && o_sys_reset_out === 1'h0, "line level");
		pulses(2);
		total = 2;
		apb(0, OFS_COUNT, bcd(total), 0);
		ext_reset_low <= 1'h1;
		repeat (8) @(posedge i_clock);
		ext_reset_low <= 1'h0;
		apb(0, OFS_COUNT, 32'h0, 0);
		apb(1, OFS_CTRL, 32'h8, 0);
		ext_gate_low <= 1'h1;
		ext_reset_low <= 1'h1;
		pulses(4);
		@(negedge i_clock);
		chk(o_sys_gate_oe === 1'h0 && o_sys_reset_oe === 1'h0, "normal drive");
		apb(0, OFS_COUNT, bcd(4), 0);
		ext_gate_low <= 1'h0;
		ext_reset_low <= 1'h0;
		repeat (4) @(posedge i_clock);
		chk(note_q.size() == 0, "answers missing");
		final_report();
	end
	// Watchdog, the run needs well under a tenth of this span
	initial
	begin
		#200000;
		chk(1'h0, "watchdog expired");
		final_report();
	end
endmodule : dcr_top_bench
